// ### mem_spaces_map.svh
`ifndef MEM_SPACES_MAP_SVH
`define MEM_SPACES_MAP_SVH

// Program space geometry
`define PROG_ADDR_W 12
`define PROG_DEPTH 4096
// Return stack depth
`define STACK_DEPTH 6
// Data space decode
`define DATA_ADDR_W 8
`define WIN_BASE 8'h40
`define WIN_LAST 8'h7f
`define RAM_BASE 8'h00
`define RAM_LAST 8'h3f
`define REG_IDX_X 8'h80
`define REG_IDX_Y 8'h81
`define REG_SHORT_V 8'h82
`define REG_SHORT_W 8'h83
`define REG_PORT_A 8'hc0
`define REG_PORT_B 8'hc1
`define REG_IRQ_OPT 8'hc8
`define REG_WIN_SEL 8'hc9
`define REG_ACC 8'hff
// Window select field
`define WIN_SEL_W 6
`define WIN_OFS_W 6
// Vectors and factory test area at top of program space
`define RESET_VECTOR 12'hffe
`define TEST_AREA_BASE 12'hf00

`endif

// ### mem_spaces_pkg.sv
package mem_spaces_pkg;
	typedef enum logic [1:0] {
		stk_none,
		stk_push,
		stk_pop
	} stack_op_t;
	typedef enum {
		data_ram,
		data_window,
		data_core_reg,
		data_periph,
		data_unmapped
	} data_region_t;
endpackage

// ### return_stack.sv
`timescale 1ns/10ps
`default_nettype none
`include "mem_spaces_map.svh"

module return_stack #(
	parameter int DEPTH = `STACK_DEPTH,
	parameter int WIDTH = `PROG_ADDR_W
) (
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Synchronous reset, active low
	input wire logic push, // Push return address
	input wire logic pop, // Pop return address
	input wire logic [WIDTH-1:0] push_addr, // Address to save
	output logic [WIDTH-1:0] top_addr, // Most recent saved address
	output logic [3:0] level, // Entries in use
	output logic overflow // Push at full depth seen
);
	logic [WIDTH-1:0] entry [DEPTH];

	initial begin
		if (DEPTH < 1 || DEPTH > 15) begin
			$error("return_stack depth out of range");
		end
	end

	// Shift-register stack: entry 0 holds the newest address
	always_ff @(posedge clk_sys) begin
		if (push) begin
			entry[0] <= push_addr;
			for (int i = 1; i < DEPTH; i++) begin
				entry[i] <= entry[i-1];
			end
		end else if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				entry[i] <= entry[i+1];
			end
		end
	end

	// Depth tracking; deepest entry is lost on overflow
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			level <= 4'h0;
			overflow <= 1'b0;
		end else if (push && !pop) begin
			if (level == 4'(DEPTH)) begin
				overflow <= 1'b1;
			end else begin
				level <= level + 4'h1;
			end
		end else if (pop && !push && level != 4'h0) begin
			level <= level - 4'h1;
		end
	end

	assign top_addr = entry[0];
endmodule

`default_nettype wire

// ### mem_spaces.sv
// Function
// - Program, data and stack spaces each have their own separate addressing path.
// - Return stack holds six 12-bit return addresses, six nesting levels.
// - A 12-bit program counter reaches 4K bytes of program memory.
// - Program space holds code, immediates, factory test area and vectors.
// - With readout protection set, external program reads are refused.
// - Protection clears on reset or together with a full program memory erase.
// - Constants in program memory are read via a 64-byte data window.
// - Data space maps RAM, A, X, Y, V, W, ports, option and select registers.
// - Data reads at 40h to 7Fh go through the program memory window.
// - Low six select bits pick the 64-byte block; software sets it first.
`timescale 1ns/10ps
`default_nettype none
`include "mem_spaces_map.svh"

module mem_spaces #(
	parameter int PROG_W = `PROG_ADDR_W,
	parameter int DATA_W = `DATA_ADDR_W
) (
	input wire logic clk_sys, // System clock, 50 MHz
	input wire logic nrst, // Synchronous reset, active low
	// Program space, core fetch path
	input wire logic pc_load, // Load program counter (jump)
	input wire logic [PROG_W-1:0] pc_load_value, // Jump target
	input wire logic pc_step, // Advance program counter
	input wire logic call, // Call or interrupt entry: save return address
	input wire logic ret, // Return: restore saved address
	output logic [PROG_W-1:0] program_counter, // Current fetch address
	output logic [7:0] fetch_data, // Program byte at fetch address
	output logic [3:0] stack_level, // Return stack entries in use
	output logic stack_overflow, // Nesting went past six levels
	// Data space, core data path
	input wire logic data_rd, // Data read strobe
	input wire logic data_wr, // Data write strobe
	input wire logic [DATA_W-1:0] data_addr, // Data space address
	input wire logic [7:0] data_wdata, // Data write value
	output logic [7:0] data_rdata, // Data read value, one cycle after strobe
	output logic data_rvalid, // Read data valid pulse
	// External programmer port
	input wire logic ext_rd, // External program read request
	input wire logic ext_wr, // External program write request
	input wire logic ext_erase, // Full program memory erase
	input wire logic [PROG_W-1:0] ext_addr, // External address
	input wire logic [7:0] ext_wdata, // External write value
	input wire logic ext_set_protect, // Program the protection option bit
	output logic [7:0] ext_rdata, // External read value
	output logic ext_rvalid, // External read answered pulse
	output logic ext_refused, // External read refused pulse
	output logic readout_protect // Protection option state
);
	localparam int PROG_DEPTH = 1 << PROG_W;

	logic [7:0] prog_mem [PROG_DEPTH];
	logic [7:0] data_ram [64];
	logic [7:0] acc, idx_x, idx_y, short_v, short_w, port_a, port_b, irq_opt;
	logic [`WIN_SEL_W-1:0] rom_window_block_select;
	logic [PROG_W-1:0] next_pc, ret_addr;
	logic [PROG_W-1:0] win_addr;
	mem_spaces_pkg::data_region_t region;
	logic ext_rd_s1, ext_rd_s2, ext_wr_s1, ext_wr_s2, ext_er_s1, ext_er_s2;
	logic ext_sp_s1, ext_sp_s2;
	logic [PROG_W-1:0] ext_addr_s1, ext_addr_s2;
	logic [7:0] ext_wd_s1, ext_wd_s2;
	logic ext_rd_d, ext_wr_d, ext_er_d, ext_sp_d;
	logic erase_busy;
	logic [PROG_W-1:0] erase_ptr;

	initial begin
		if (PROG_W != 12 || DATA_W != 8) begin
			$error("mem_spaces supports only 12-bit program and 8-bit data addresses");
		end
	end

	// Return stack lives in its own space, reached only by call and return
	return_stack #(.DEPTH(`STACK_DEPTH), .WIDTH(PROG_W)) u_stack (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.push(call),
		.pop(ret),
		.push_addr(program_counter + PROG_W'(1)),
		.top_addr(ret_addr),
		.level(stack_level),
		.overflow(stack_overflow)
	);

	// Next fetch address: return, jump, or step
	always_comb begin
		next_pc = program_counter;
		if (ret) begin
			next_pc = ret_addr;
		end else if (pc_load) begin
			next_pc = pc_load_value;
		end else if (pc_step) begin
			next_pc = program_counter + PROG_W'(1);
		end
	end

	// Program counter starts at the reset vector
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			program_counter <= `RESET_VECTOR;
		end else begin
			program_counter <= next_pc;
		end
	end

	// Fetch path reads program memory only through the program counter
	always_ff @(posedge clk_sys) begin
		fetch_data <= prog_mem[next_pc];
	end

	// Window address: block select over the offset within the block
	assign win_addr = {rom_window_block_select, data_addr[`WIN_OFS_W-1:0]};

	// Data space region decode
	always_comb begin
		region = mem_spaces_pkg::data_unmapped;
		if (data_addr <= `RAM_LAST) begin
			region = mem_spaces_pkg::data_ram;
		end else if (data_addr >= `WIN_BASE && data_addr <= `WIN_LAST) begin
			region = mem_spaces_pkg::data_window;
		end else if ((data_addr >= `REG_IDX_X && data_addr <= `REG_SHORT_W) ||
			data_addr == `REG_ACC) begin
			region = mem_spaces_pkg::data_core_reg;
		end else if (data_addr == `REG_PORT_A || data_addr == `REG_PORT_B ||
			data_addr == `REG_IRQ_OPT || data_addr == `REG_WIN_SEL) begin
			region = mem_spaces_pkg::data_periph;
		end
	end

	// Data writes; window is read-only, select and option are write-only
	always_ff @(posedge clk_sys) begin
		if (data_wr) begin
			unique case (region)
				mem_spaces_pkg::data_ram: data_ram[data_addr[5:0]] <= data_wdata;
				mem_spaces_pkg::data_core_reg: begin
					if (data_addr == `REG_ACC) acc <= data_wdata;
					if (data_addr == `REG_IDX_X) idx_x <= data_wdata;
					if (data_addr == `REG_IDX_Y) idx_y <= data_wdata;
					if (data_addr == `REG_SHORT_V) short_v <= data_wdata;
					if (data_addr == `REG_SHORT_W) short_w <= data_wdata;
				end
				mem_spaces_pkg::data_periph: begin
					if (data_addr == `REG_IRQ_OPT) irq_opt <= data_wdata;
					if (data_addr == `REG_WIN_SEL) begin
						rom_window_block_select <= data_wdata[`WIN_SEL_W-1:0];
					end
				end
				mem_spaces_pkg::data_window, mem_spaces_pkg::data_unmapped: begin
				end
			endcase
		end
	end

	// Port registers clear at reset; others are left undefined
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			port_a <= 8'h00;
			port_b <= 8'h00;
		end else if (data_wr && data_addr == `REG_PORT_A) begin
			port_a <= data_wdata;
		end else if (data_wr && data_addr == `REG_PORT_B) begin
			port_b <= data_wdata;
		end
	end

	// Data reads answer one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			data_rdata <= 8'h00;
			data_rvalid <= 1'b0;
		end else begin
			data_rvalid <= data_rd;
			if (data_rd) begin
				unique case (region)
					mem_spaces_pkg::data_ram: data_rdata <= data_ram[data_addr[5:0]];
					mem_spaces_pkg::data_window: data_rdata <= prog_mem[win_addr];
					mem_spaces_pkg::data_core_reg: begin
						unique case (data_addr)
							`REG_IDX_X: data_rdata <= idx_x;
							`REG_IDX_Y: data_rdata <= idx_y;
							`REG_SHORT_V: data_rdata <= short_v;
							`REG_SHORT_W: data_rdata <= short_w;
							default: data_rdata <= acc;
						endcase
					end
					mem_spaces_pkg::data_periph: begin
						if (data_addr == `REG_PORT_A) data_rdata <= port_a;
						else if (data_addr == `REG_PORT_B) data_rdata <= port_b;
						else data_rdata <= 8'h00; // Write-only registers
					end
					mem_spaces_pkg::data_unmapped: data_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Programmer strobes come from outside: two-flop synchronisers
	always_ff @(posedge clk_sys) begin
		ext_rd_s1 <= ext_rd;
		ext_rd_s2 <= ext_rd_s1;
		ext_wr_s1 <= ext_wr;
		ext_wr_s2 <= ext_wr_s1;
		ext_er_s1 <= ext_erase;
		ext_er_s2 <= ext_er_s1;
		ext_sp_s1 <= ext_set_protect;
		ext_sp_s2 <= ext_sp_s1;
		ext_addr_s1 <= ext_addr; // Held stable while the strobe is high
		ext_addr_s2 <= ext_addr_s1;
		ext_wd_s1 <= ext_wdata;
		ext_wd_s2 <= ext_wd_s1;
		ext_rd_d <= ext_rd_s2;
		ext_wr_d <= ext_wr_s2;
		ext_er_d <= ext_er_s2;
		ext_sp_d <= ext_sp_s2;
	end

	// Protection bit: set by programming, cleared by reset or by a completed erase
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			readout_protect <= 1'b0;
		end else if (ext_sp_s2 && !ext_sp_d) begin
			readout_protect <= 1'b1;
		end else if (erase_busy && erase_ptr == PROG_W'(PROG_DEPTH - 1)) begin
			readout_protect <= 1'b0;
		end
	end

	// Full erase sweeps every program byte to the blank value
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			erase_busy <= 1'b0;
			erase_ptr <= '0;
		end else if (erase_busy) begin
			erase_ptr <= erase_ptr + PROG_W'(1);
			if (erase_ptr == PROG_W'(PROG_DEPTH - 1)) erase_busy <= 1'b0;
		end else if (ext_er_s2 && !ext_er_d) begin
			erase_busy <= 1'b1;
			erase_ptr <= '0;
		end
	end

	// Program memory writes: erase sweep or external programming
	always_ff @(posedge clk_sys) begin
		if (erase_busy) begin
			prog_mem[erase_ptr] <= 8'hff;
		end else if (ext_wr_s2 && !ext_wr_d && !readout_protect) begin
			prog_mem[ext_addr_s2] <= ext_wd_s2;
		end
	end

	// External readout, refused while protected
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ext_rdata <= 8'h00;
			ext_rvalid <= 1'b0;
			ext_refused <= 1'b0;
		end else begin
			ext_rvalid <= 1'b0;
			ext_refused <= 1'b0;
			if (ext_rd_s2 && !ext_rd_d) begin
				if (readout_protect || erase_busy) begin
					ext_refused <= 1'b1;
					ext_rdata <= 8'h00;
				end else begin
					ext_rvalid <= 1'b1;
					ext_rdata <= prog_mem[ext_addr_s2];
				end
			end
		end
	end
endmodule

`default_nettype wire

// ### mem_spaces_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mem_spaces_monitor #(
	parameter int PROG_W = 12
) (
	input wire logic clk_sys, // Clock
	input wire logic nrst, // Reset
	input wire logic pc_load, // Jump
	input wire logic [PROG_W-1:0] pc_load_value, // Target
	input wire logic call, // Call
	input wire logic ret, // Return
	input wire logic [PROG_W-1:0] program_counter, // PC
	input wire logic [3:0] stack_level, // Depth
	input wire logic stack_overflow, // Overflow
	input wire logic data_rd, // Read
	input wire logic [7:0] data_addr, // Address
	input wire logic [7:0] data_rdata, // Read value
	input wire logic data_rvalid, // Read valid
	input wire logic [7:0] ext_rdata, // Ext value
	input wire logic ext_rvalid, // Ext valid
	input wire logic ext_refused // Ext refused
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// A call followed at once by a return
	sequence s_call;
		call && !ret;
	endsequence
	sequence s_call_ret;
		s_call ##1 (ret && !call);
	endsequence
	a_reset_state: assert property (disable iff (1'h0) !nrst |=>
		program_counter == 12'hffe && stack_level == 4'h0) else $error("bad reset");
	a_jump_target: assert property (pc_load && !ret |=>
		program_counter == $past(pc_load_value)) else $error("bad jump");
	a_return_addr: assert property (s_call_ret |=>
		program_counter == $past(program_counter, 2) + 1'h1) else $error("bad return");
	a_push_level: assert property ((s_call and (stack_level < 4'h6)) |=>
		stack_level == $past(stack_level) + 1'h1) else $error("bad depth");
	a_overflow_set: assert property ((s_call and (stack_level == 4'h6)) |=>
		stack_overflow && stack_level == 4'h6) else $error("bad overflow");
	a_read_answer: assert property (data_rd |=> data_rvalid) else $error("no answer");
	a_wo_zero: assert property (data_rd && (data_addr == 8'hc8 || data_addr == 8'hc9) |=>
		data_rdata == 8'h00) else $error("bad wo read");
	a_refused_clean: assert property (ext_refused |->
		ext_rdata == 8'h00 && !ext_rvalid) else $error("bad refusal");
endmodule
bind mem_spaces mem_spaces_monitor #(.PROG_W(PROG_W)) u_mon (.clk_sys, .nrst, .pc_load,
	.pc_load_value, .call, .ret, .program_counter, .stack_level, .stack_overflow, .data_rd,
	.data_addr, .data_rdata, .data_rvalid, .ext_rdata, .ext_rvalid, .ext_refused);
`default_nettype wire

// ### core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic clk_sys, // Clock
	input wire logic [7:0] data_rdata, // Read value
	input wire logic data_rvalid, // Read valid
	output logic data_rd, // Read strobe
	output logic data_wr, // Write strobe
	output logic [7:0] data_addr, // Address
	output logic [7:0] data_wdata // Write value
);
	// Idle bus
	initial begin
		{data_rd, data_wr, data_addr, data_wdata} = 18'h00000;
	end
	// One write; released lines show the inverse
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		#1;
		{data_wr, data_addr, data_wdata} = {1'h1, a, v};
		@(posedge clk_sys);
		#1;
		{data_wr, data_addr, data_wdata} = {1'h0, ~a, ~v};
	endtask
	// One read; answer stands the cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic ok, output logic [7:0] v);
		@(posedge clk_sys);
		#1;
		{data_rd, data_addr} = {1'h1, a};
		@(posedge clk_sys);
		#1;
		{data_rd, data_addr} = {1'h0, ~a};
		ok = data_rvalid;
		v = data_rdata;
	endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_sys = 1'h0, nrst = 1'h0, pc_load = 1'h0, pc_step = 1'h0, call = 1'h0, ret = 1'h0;
	logic ext_rd = 1'h0, ext_wr = 1'h0, ext_erase = 1'h0, ext_set_protect = 1'h0, ok, rf;
	logic [11:0] pc_load_value = 12'h000, ext_addr = 12'h000, program_counter;
	logic [7:0] ext_wdata = 8'h00, fetch_data, data_rdata, ext_rdata, data_addr, data_wdata, d;
	logic [3:0] stack_level;
	logic stack_overflow, data_rd, data_wr, data_rvalid, ext_rvalid, ext_refused, readout_protect;
	int miscompares = 0, total_checks = 0;
	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;
	mem_spaces u_dut (.clk_sys, .nrst, .pc_load, .pc_load_value, .pc_step, .call, .ret,
		.program_counter, .fetch_data, .stack_level, .stack_overflow, .data_rd, .data_wr,
		.data_addr, .data_wdata, .data_rdata, .data_rvalid, .ext_rd, .ext_wr, .ext_erase,
		.ext_addr, .ext_wdata, .ext_set_protect, .ext_rdata, .ext_rvalid, .ext_refused,
		.readout_protect);
	core_model u_core (.clk_sys, .data_rdata, .data_rvalid, .data_rd, .data_wr, .data_addr,
		.data_wdata);
	task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic do_reset;
		nrst = 1'h0;
		tick(8);
		nrst = 1'h1;
	endtask
	// Programmer strobe held four cycles, then four idle
	task automatic ext_op(input logic [2:0] m, input logic [11:0] a, input logic [7:0] v);
		{ext_addr, ext_wdata} = {a, v};
		{ext_erase, ext_set_protect, ext_wr} = m;
		tick(4);
		{ext_erase, ext_set_protect, ext_wr} = 3'h0;
		ext_addr = ~a;
		tick(4);
	endtask
	task automatic ext_read(input logic [11:0] a);
		int i;
		ext_addr = a;
		ext_rd = 1'h1;
		for (i = 0; i < 8 && !(ext_rvalid || ext_refused); i++) begin
			tick(1);
		end
		if (i == 8) begin
			chk("wait", 16'h0001, 16'h0000);
			close_out();
		end
		{rf, ok, d} = {ext_refused, ext_rvalid, ext_rdata};
		ext_rd = 1'h0;
		ext_addr = ~a;
		tick(4);
	endtask
	task automatic t_window;
		ext_op(3'h1, 12'h14a, 8'ha5);
		ext_op(3'h1, 12'h07f, 8'h3c);
		u_core.wr(8'hc9, 8'h05);
		u_core.rd(8'h4a, ok, d);
		chk("win", {ok, d}, 9'h1a5);
		u_core.wr(8'h4a, 8'h00);
		u_core.rd(8'h4a, ok, d);
		chk("win ro", d, 8'ha5);
		u_core.wr(8'hc9, 8'h01);
		u_core.rd(8'h7f, ok, d);
		chk("win top", d, 8'h3c);
		{pc_load, pc_load_value} = 13'h114a;
		tick(1);
		chk("fetch", {program_counter, fetch_data}, 20'h14aa5);
		pc_load_value = 12'hfff;
		tick(1);
		{pc_load, pc_step} = 2'h1;
		tick(1);
		pc_step = 1'h0;
		chk("wrap", program_counter, 12'h000);
	endtask
	task automatic t_data;
		logic [7:0] adr [11] = '{8'h00, 8'h3f, 8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'hc0, 8'hc1,
			8'hc8, 8'hc9};
		for (int i = 0; i < 11; i++) begin
			u_core.wr(adr[i], adr[i] ^ 8'h5a);
		end
		for (int i = 0; i < 11; i++) begin
			u_core.rd(adr[i], ok, d);
			chk("data", d, i < 9 ? adr[i] ^ 8'h5a : 8'h00);
		end
	endtask
	task automatic t_protect;
		int i;
		ext_read(12'h14a);
		chk("ext rd", {rf, ok, d}, 10'h1a5);
		ext_op(3'h2, 12'h000, 8'h00);
		ext_read(12'h14a);
		chk("refused", {readout_protect, rf, ok, d}, 11'h600);
		ext_op(3'h1, 12'h14a, 8'h00);
		u_core.wr(8'hc9, 8'h05);
		u_core.rd(8'h4a, ok, d);
		chk("win prot", d, 8'ha5);
		ext_op(3'h4, 12'h000, 8'h00);
		chk("prot held", readout_protect, 1'h1);
		for (i = 0; i < 5000 && readout_protect; i++) begin
			tick(1);
		end
		if (i == 5000) begin
			chk("erase wait", 20'h00001, 20'h00000);
			close_out();
		end
		ext_read(12'h14a);
		chk("erased", {readout_protect, rf, ok, d}, 11'h1ff);
	endtask
	task automatic t_stack;
		{pc_load, pc_load_value} = 13'h1010;
		tick(1);
		call = 1'h1;
		for (int i = 0; i < 6; i++) begin
			pc_load_value = 12'h100 + 12'(i * 16);
			tick(1);
			chk("level", stack_level, 4'(i + 1));
		end
		{call, pc_load} = 2'h0;
		u_core.wr(8'h00, 8'hee);
		ret = 1'h1;
		for (int i = 5; i >= 0; i--) begin
			tick(1);
			chk("ret", {stack_level, program_counter},
				{4'(i), i == 0 ? 12'h011 : 12'h0f1 + 12'(i * 16)});
		end
		{ret, call} = 2'h1;
		tick(1);
		{ret, call} = 2'h2;
		tick(1);
		ret = 1'h0;
		chk("call ret", program_counter, 12'h012);
		for (int i = 0; i < 7; i++) begin
			call = 1'h1;
			tick(1);
			call = 1'h0;
			tick(1);
		end
		chk("ovf", {stack_overflow, stack_level}, 5'h16);
		do_reset();
		chk("rst", {stack_overflow, program_counter}, 13'h0ffe);
		u_core.rd(8'hc0, ok, d);
		chk("port rst", {ok, d}, 9'h100);
	endtask
	// Main sequence
	initial begin
		do_reset();
		chk("init", {readout_protect, stack_level}, 5'h00);
		t_window();
		t_data();
		t_protect();
		t_stack();
		close_out();
	end
endmodule
`default_nettype wire
